// ==== iaet_consts.vh ====
// constants for the interrupt and event transfer block
`ifndef IAET_CONSTS_VH
`define IAET_CONSTS_VH
`define IAET_NODES 96
`define IAET_NODE_W 7
`define IAET_PRIO_W 4
`define IAET_CHANS 8
`define IAET_CHAN_W 3
`define IAET_ADDR_W 24
`define IAET_CNT_W 8
`define IAET_ERU_CH 4
`define IAET_SHARED 4
`define IAET_LAT_JC 4'h7
`define IAET_LAT_NJC 4'hB
`define IAET_TRAP_NODE 7'h7F
`define IAET_EDGE_RISE 2'h1
`define IAET_EDGE_FALL 2'h2
`define IAET_EDGE_BOTH 2'h3
`define IAET_ERU_NODE0 7'h5C
`define IAET_SHARED_NODE0 7'h58
`endif

// ==== iaet_top.v ====
// interrupt controller with event transfer channels and request unit
//
// Operation
// - each node is steered either to vectored service or to an event transfer channel.
// - a vectored service suspends the program and branches to the node's vector entry.
// - an event transfer steals exactly one cycle from the cpu and takes no vector.
// - a transfer moves one byte or word then bumps source, destination or both pointers.
// - each transfer decrements the channel count unless the channel is continuous.
// - a channel whose count is zero raises a vectored interrupt to its node instead.
// - there are eight channels, each with its own pointers and count.
// - service starts no earlier than 7 clocks after a request with jump cache, 11 without.
// - there are 96 nodes, each with request flag, enable flag and priority field.
// - most sources own a node, and select registers pick the source of shared nodes.
// - the request unit takes the external lines only and routes them to nodes.
// - the request unit has 4 trigger channels, a routing matrix and 4 gating units.
// - each trigger channel detects rising, falling or both edges as configured.
// - each gating unit passes or blocks its events on a pattern match or miss.
// - a hardware trap branches to a service routine like a standard interrupt.
`timescale 1ns/10ps
`include "iaet_consts.vh"
module iaet_top #(
  parameter NODES = `IAET_NODES,
  parameter CHANS = `IAET_CHANS
) (
  // clock and reset
  input wire clk_in,
  input wire nrst_in,
  // request sources
  input wire [NODES-1:0] src_req_in,
  input wire [4*`IAET_SHARED-1:0] shared_src_in,
  input wire [2*`IAET_SHARED-1:0] source_selection_regs_in,
  input wire [`IAET_ERU_CH-1:0] ext_req_in,
  input wire trap_in,
  // node configuration
  input wire [NODES-1:0] node_en_in,
  input wire [NODES*`IAET_PRIO_W-1:0] node_prio_in,
  input wire [NODES-1:0] node_use_pec_in,
  input wire [NODES*`IAET_CHAN_W-1:0] node_chan_in,
  input wire jump_cache_in,
  // request unit configuration
  input wire [2*`IAET_ERU_CH-1:0] eru_edge_in,
  input wire [2*`IAET_ERU_CH-1:0] eru_route_in,
  input wire [`IAET_ERU_CH-1:0] eru_pattern_in,
  input wire [`IAET_ERU_CH-1:0] eru_on_miss_in,
  // channel setup writes
  input wire chan_wr_in,
  input wire [`IAET_CHAN_W-1:0] chan_sel_in,
  input wire [`IAET_ADDR_W-1:0] chan_src_in,
  input wire [`IAET_ADDR_W-1:0] chan_dst_in,
  input wire [`IAET_CNT_W-1:0] chan_cnt_in,
  input wire chan_byte_in,
  input wire chan_inc_src_in,
  input wire chan_inc_dst_in,
  input wire chan_cont_in,
  // cpu handshake
  input wire cpu_ack_in,
  input wire mem_done_in,
  // cpu and memory side
  output reg irq_out,
  output reg [`IAET_NODE_W-1:0] vector_out,
  output reg trap_out,
  output reg steal_out,
  output reg xfer_req_out,
  output reg [`IAET_ADDR_W-1:0] xfer_src_out,
  output reg [`IAET_ADDR_W-1:0] xfer_dst_out,
  output reg xfer_byte_out,
  output reg [NODES-1:0] node_flag_out
);
  localparam S_IDLE = 4'h1;
  localparam S_WAIT = 4'h2;
  localparam S_IRQ = 4'h4;
  localparam S_XFER = 4'h8;

  reg [3:0] state;
  reg [3:0] lat_cnt;
  reg [`IAET_NODE_W-1:0] cur_node;
  reg cur_pec;
  reg cur_trap;
  reg [`IAET_ADDR_W-1:0] src_ptr [0:CHANS-1];
  reg [`IAET_ADDR_W-1:0] dst_ptr [0:CHANS-1];
  reg [`IAET_CNT_W-1:0] xcnt [0:CHANS-1];
  reg [CHANS-1:0] cbyte;
  reg [CHANS-1:0] cinc_s;
  reg [CHANS-1:0] cinc_d;
  reg [CHANS-1:0] ccont;
  reg [`IAET_ERU_CH-1:0] ext_s1;
  reg [`IAET_ERU_CH-1:0] ext_s2;
  reg [`IAET_ERU_CH-1:0] ext_d;
  reg [NODES-1:0] src_s1;
  reg [NODES-1:0] src_s2;
  reg [NODES-1:0] src_d;
  reg [4*`IAET_SHARED-1:0] shs_s1;
  reg [4*`IAET_SHARED-1:0] shs_s2;
  reg [4*`IAET_SHARED-1:0] shs_d;
  reg trap_s1;
  reg trap_s2;
  reg trap_pend;
  // own loop variables for each process, so no process wakes another
  integer i;
  integer ti;
  integer tk;
  integer si;
  integer ai;

  function [1:0] pick2;
    input [1:0] sel;
    input [3:0] v;
    begin
      pick2 = {1'b0, v[sel]};
    end
  endfunction

  // trigger channels; the route field picks the gating unit
  reg [`IAET_ERU_CH-1:0] trig;
  reg [`IAET_ERU_CH-1:0] gate_ev;
  reg [`IAET_ERU_CH-1:0] gate_out;
  always @* begin
    gate_ev = {`IAET_ERU_CH{1'b0}};
    for (ti = 0; ti < `IAET_ERU_CH; ti = ti + 1) begin
      trig[ti] = (eru_edge_in[2*ti] & ext_s2[ti] & ~ext_d[ti]) |
        (eru_edge_in[2*ti+1] & ~ext_s2[ti] & ext_d[ti]);
      for (tk = 0; tk < `IAET_ERU_CH; tk = tk + 1) begin
        if (trig[ti] && eru_route_in[2*ti +: 2] == tk[1:0]) begin
          gate_ev[tk] = 1'b1;
        end
      end
    end
    for (ti = 0; ti < `IAET_ERU_CH; ti = ti + 1) begin
      gate_out[ti] = gate_ev[ti] &
        ((eru_pattern_in == ext_s2) ^ eru_on_miss_in[ti]);
    end
  end

  // edge events feeding each node; shared nodes take the selected source
  reg [NODES-1:0] node_ev;
  reg [1:0] sel_bit;
  always @* begin
    node_ev = src_s2 & ~src_d;
    sel_bit = 2'h0;
    // edges are taken before the mux, so a select change makes no event
    for (si = 0; si < `IAET_SHARED; si = si + 1) begin
      sel_bit = pick2(source_selection_regs_in[2*si +: 2],
        shs_s2[4*si +: 4] & ~shs_d[4*si +: 4]);
      node_ev[`IAET_SHARED_NODE0 + si] = sel_bit[0];
    end
    for (si = 0; si < `IAET_ERU_CH; si = si + 1) begin
      node_ev[`IAET_ERU_NODE0 + si] = gate_out[si];
    end
  end

  // arbitration: highest priority value, lowest index on ties
  reg found;
  reg [`IAET_NODE_W-1:0] win;
  reg [`IAET_PRIO_W-1:0] win_prio;
  always @* begin
    found = 1'b0;
    win = {`IAET_NODE_W{1'b0}};
    win_prio = {`IAET_PRIO_W{1'b0}};
    for (ai = 0; ai < NODES; ai = ai + 1) begin
      if (node_flag_out[ai] && node_en_in[ai] &&
          (!found || node_prio_in[ai*`IAET_PRIO_W +: `IAET_PRIO_W] >
          win_prio)) begin
        found = 1'b1;
        win = ai[`IAET_NODE_W-1:0];
        win_prio = node_prio_in[ai*`IAET_PRIO_W +: `IAET_PRIO_W];
      end
    end
  end

  wire [`IAET_CHAN_W-1:0] cur_ch;
  assign cur_ch = node_chan_in[cur_node*`IAET_CHAN_W +: `IAET_CHAN_W];
  wire [`IAET_ADDR_W-1:0] step;
  assign step = cbyte[cur_ch] ? 24'h000001 : 24'h000002;
  wire [3:0] lat_target;
  assign lat_target = jump_cache_in ? `IAET_LAT_JC : `IAET_LAT_NJC;
  wire accept;
  assign accept = (state == S_IDLE) && (found || trap_pend);
  wire grant_pec;
  assign grant_pec = node_use_pec_in[win] &&
    xcnt[node_chan_in[win*`IAET_CHAN_W +: `IAET_CHAN_W]] != 8'h00;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_s1 <= 4'h0;
      ext_s2 <= 4'h0;
      ext_d <= 4'h0;
      src_s1 <= {NODES{1'b0}};
      src_s2 <= {NODES{1'b0}};
      src_d <= {NODES{1'b0}};
      shs_s1 <= 16'h0000;
      shs_s2 <= 16'h0000;
      shs_d <= 16'h0000;
      trap_s1 <= 1'b0;
      trap_s2 <= 1'b0;
      trap_pend <= 1'b0;
      node_flag_out <= {NODES{1'b0}};
      state <= S_IDLE;
      lat_cnt <= 4'h0;
      cur_node <= 7'h00;
      cur_pec <= 1'b0;
      cur_trap <= 1'b0;
      irq_out <= 1'b0;
      vector_out <= 7'h00;
      trap_out <= 1'b0;
      steal_out <= 1'b0;
      xfer_req_out <= 1'b0;
      xfer_src_out <= 24'h000000;
      xfer_dst_out <= 24'h000000;
      xfer_byte_out <= 1'b0;
      cbyte <= {CHANS{1'b0}};
      cinc_s <= {CHANS{1'b0}};
      cinc_d <= {CHANS{1'b0}};
      ccont <= {CHANS{1'b0}};
      for (i = 0; i < CHANS; i = i + 1) begin
        src_ptr[i] <= 24'h000000;
        dst_ptr[i] <= 24'h000000;
        xcnt[i] <= 8'h00;
      end
    end else begin
      // pins pass two flops before any edge logic looks at them
      ext_s1 <= ext_req_in;
      ext_s2 <= ext_s1;
      ext_d <= ext_s2;
      src_s1 <= src_req_in;
      src_s2 <= src_s1;
      src_d <= src_s2;
      shs_s1 <= shared_src_in;
      shs_s2 <= shs_s1;
      shs_d <= shs_s2;
      trap_s1 <= trap_in;
      trap_s2 <= trap_s1;
      if (trap_s2) begin
        trap_pend <= 1'b1;
      end else if (accept) begin
        trap_pend <= 1'b0;
      end
      // set wins over the acceptance clear
      node_flag_out <= (node_flag_out &
        ~(accept && !trap_pend ? ({{(NODES-1){1'b0}}, 1'b1} << win)
        : {NODES{1'b0}})) | node_ev;
      if (chan_wr_in) begin
        src_ptr[chan_sel_in] <= chan_src_in;
        dst_ptr[chan_sel_in] <= chan_dst_in;
        xcnt[chan_sel_in] <= chan_cnt_in;
        cbyte[chan_sel_in] <= chan_byte_in;
        cinc_s[chan_sel_in] <= chan_inc_src_in;
        cinc_d[chan_sel_in] <= chan_inc_dst_in;
        ccont[chan_sel_in] <= chan_cont_in;
      end
      steal_out <= 1'b0;
      case (state)
        S_IDLE: begin
          if (accept) begin
            // a pending trap wins over every node request at acceptance
            cur_trap <= trap_pend;
            cur_node <= trap_pend ? `IAET_TRAP_NODE : win;
            cur_pec <= !trap_pend && grant_pec;
            lat_cnt <= 4'h1;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          // request was seen three cycles before this counter starts
          lat_cnt <= lat_cnt + 4'h1;
          if (lat_cnt + 4'h3 >= lat_target) begin
            if (cur_pec) begin
              xfer_req_out <= 1'b1;
              steal_out <= 1'b1;
              xfer_src_out <= src_ptr[cur_ch];
              xfer_dst_out <= dst_ptr[cur_ch];
              xfer_byte_out <= cbyte[cur_ch];
              state <= S_XFER;
            end else begin
              irq_out <= 1'b1;
              trap_out <= cur_trap;
              vector_out <= cur_node;
              state <= S_IRQ;
            end
          end
        end
        S_IRQ: begin
          if (cpu_ack_in) begin
            irq_out <= 1'b0;
            trap_out <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_XFER: begin
          if (mem_done_in) begin
            xfer_req_out <= 1'b0;
            if (cinc_s[cur_ch]) begin
              src_ptr[cur_ch] <= src_ptr[cur_ch] + step;
            end
            if (cinc_d[cur_ch]) begin
              dst_ptr[cur_ch] <= dst_ptr[cur_ch] + step;
            end
            if (!ccont[cur_ch]) begin
              xcnt[cur_ch] <= xcnt[cur_ch] - 8'h01;
            end
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // iaet_top

// ==== iaet_cpu_model.sv ====
// cpu core model that answers services after a chosen delay
`timescale 1ns/10ps
module iaet_cpu_model (
  // clock and reset
  input wire clk_in,
  input wire nrst_in,
  // service requests and answer delay
  input wire irq_in,
  input wire xfer_in,
  input wire [3:0] dly_in,
  // answers
  output reg cpu_ack_out,
  output reg mem_done_out
);
  reg [3:0] cnt;
  // answer is a single cycle and the count restarts, so a held request is acked again after the delay
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 4'h0;
      cpu_ack_out <= 1'b0;
      mem_done_out <= 1'b0;
    end else if (cpu_ack_out || mem_done_out || !(irq_in || xfer_in)) begin
      cnt <= 4'h0;
      cpu_ack_out <= 1'b0;
      mem_done_out <= 1'b0;
    end else if (cnt == dly_in) begin
      cpu_ack_out <= irq_in;
      mem_done_out <= xfer_in;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // iaet_cpu_model

// ==== iaet_top_sva.sv ====
// port assertions for the interrupt block
`timescale 1ns/10ps
`include "iaet_consts.vh"
module iaet_top_sva #(
  parameter NODES = 96
) (
  input wire clk_in,
  input wire nrst_in,
  input wire [NODES-1:0] node_en_in,
  input wire cpu_ack_in,
  input wire mem_done_in,
  input wire irq_out,
  input wire [`IAET_NODE_W-1:0] vector_out,
  input wire trap_out,
  input wire steal_out,
  input wire xfer_req_out,
  input wire [`IAET_ADDR_W-1:0] xfer_src_out,
  input wire [`IAET_ADDR_W-1:0] xfer_dst_out,
  input wire xfer_byte_out,
  input wire [NODES-1:0] node_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_irq_hold: assert property (irq_out && !cpu_ack_in |=> irq_out
    && $stable(vector_out)) else $error("irq dropped early");
  a_ack_drop: assert property (irq_out && cpu_ack_in |-> ##[1:2] !irq_out)
    else $error("irq held after ack");
  a_steal_one: assert property (steal_out |=> !steal_out)
    else $error("steal longer than a cycle");
  a_steal_start: assert property ($rose(xfer_req_out) |-> ##[0:1] steal_out)
    else $error("transfer without steal");
  a_steal_novec: assert property (steal_out |-> !irq_out)
    else $error("steal with vector");
  a_xfer_hold: assert property (xfer_req_out && !mem_done_in |=> xfer_req_out
    && $stable({xfer_src_out, xfer_dst_out, xfer_byte_out}))
    else $error("transfer changed early");
  a_one_svc: assert property (!(irq_out && xfer_req_out))
    else $error("two services at once");
  a_trap_vec: assert property (trap_out |-> vector_out == `IAET_TRAP_NODE)
    else $error("trap vector wrong");
  a_grant_en: assert property ($rose(irq_out) && !trap_out |->
    node_en_in[vector_out] && !node_flag_out[vector_out])
    else $error("grant of disabled or uncleared node");
endmodule // iaet_top_sva
bind iaet_top iaet_top_sva #(.NODES(NODES)) u_iaet_top_sva (.clk_in(clk_in),
  .nrst_in(nrst_in), .node_en_in(node_en_in), .cpu_ack_in(cpu_ack_in),
  .mem_done_in(mem_done_in), .irq_out(irq_out), .vector_out(vector_out),
  .trap_out(trap_out), .steal_out(steal_out), .xfer_req_out(xfer_req_out),
  .xfer_src_out(xfer_src_out), .xfer_dst_out(xfer_dst_out),
  .xfer_byte_out(xfer_byte_out), .node_flag_out(node_flag_out));

// ==== iaet_top_test.sv ====
// self-checking bench for the interrupt block
`timescale 1ns/10ps
module iaet_top_test;
  reg clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [95:0] src = '0, en = '0, peripheral_event_transfer_ctrl = '0;
  reg [383:0] prio = '0;
  reg [287:0] chn = '0;
  reg [15:0] shs = '0;
  reg [7:0] ssel = '0, edg = '0, rte = '0, ccnt = '0;
  reg [3:0] ext = '0, pat = 4'h5, miss = '0, dly = '0;
  reg trap = 0, jc = 1, wr = 0, byt = 0, isrc = 0, idst = 0, cont = 0;
  reg [2:0] csel = '0;
  reg [23:0] csrc = '0, cdst = '0;
  reg [31:0] r = 32'h1C71;
  wire ack, done, irq, trp, steal, xreq, xbyte;
  wire [6:0] vec;
  wire [23:0] xs, xd;
  wire [95:0] flg;
  reg [23:0] m_s[0:7], m_d[0:7];
  reg [7:0] m_cnt[0:7];
  reg [3:0] m_md[0:7];
  reg [56:0] expq[$];
  integer n_errors = 0, num_checks = 0;
  initial forever #2.5 clk_in = ~clk_in;
  iaet_top u_iaet_top (.clk_in(clk_in), .nrst_in(nrst_in), .src_req_in(src),
    .shared_src_in(shs), .source_selection_regs_in(ssel), .ext_req_in(ext),
    .trap_in(trap), .node_en_in(en), .node_prio_in(prio),
    .node_use_pec_in(peripheral_event_transfer_ctrl), .node_chan_in(chn), .jump_cache_in(jc),
    .eru_edge_in(edg), .eru_route_in(rte), .eru_pattern_in(pat),
    .eru_on_miss_in(miss), .chan_wr_in(wr), .chan_sel_in(csel),
    .chan_src_in(csrc), .chan_dst_in(cdst), .chan_cnt_in(ccnt),
    .chan_byte_in(byt), .chan_inc_src_in(isrc), .chan_inc_dst_in(idst),
    .chan_cont_in(cont), .cpu_ack_in(ack), .mem_done_in(done),
    .irq_out(irq), .vector_out(vec), .trap_out(trp), .steal_out(steal),
    .xfer_req_out(xreq), .xfer_src_out(xs), .xfer_dst_out(xd),
    .xfer_byte_out(xbyte), .node_flag_out(flg));
  iaet_cpu_model u_iaet_cpu_model (.clk_in(clk_in), .nrst_in(nrst_in),
    .irq_in(irq | trp), .xfer_in(xreq), .dly_in(dly), .cpu_ack_out(ack),
    .mem_done_out(done));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task step(input integer k);
    begin repeat (k) @(posedge clk_in); #1; end
  endtask
  task chk(input [56:0] seen, input [56:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        n_errors = n_errors + 1;
        $display("FAIL %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task vq(input integer v);
    expq.push_back({2'b0, v[6:0], 48'h0});
  endtask
  task pulse(input integer v);
    begin src[v] = 1'b1; step(2); src[v] = 1'b0; end
  endtask
  // waits for the next service and compares it with the model's front entry
  task svc(output integer lat);
    integer k;
    reg [56:0] e;
    begin
      lat = 0;
      while ((irq | xreq | trp) !== 1'b1 && lat < 60) begin
        step(1);
        lat = lat + 1;
      end
      chk(lat < 60, 1);
      e = expq.pop_front();
      chk({xreq, xreq & xbyte, xreq ? 7'h0 : vec, xreq ? {xs, xd} : 48'h0},
        e);
      chk(steal, e[56]);
      chk(trp, !e[56] && e[54:48] == 7'h7F);
      k = 0;
      while ((irq | xreq | trp) !== 1'b0 && k < 30) begin
        step(1);
        k = k + 1;
      end
      chk(k < 30, 1);
      step(1);
    end
  endtask
  // channel model: pointer steps of 1 for bytes and 2 for words
  task req(input integer c);
    begin
      if (!m_md[c][3] && m_cnt[c] == 0) vq(64 + c);
      else begin
        expq.push_back({1'b1, m_md[c][0], 7'h0, m_s[c], m_d[c]});
        if (m_md[c][1]) m_s[c] = m_s[c] + {~m_md[c][0], m_md[c][0]};
        if (m_md[c][2]) m_d[c] = m_d[c] + {~m_md[c][0], m_md[c][0]};
        if (!m_md[c][3]) m_cnt[c] = m_cnt[c] - 8'h1;
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_errors = n_errors + 1;
    conclude;
  end
  initial begin : main
    integer i, c, n, l1, l2;
    step(8);
    nrst_in = 1'b1;
    step(2);
    r = lfsr(r);
    n = r % 40;
    en[n] = 1'b1;
    vq(n); pulse(n); svc(l1);
    chk(flg[n], 0);
    jc = 1'b0; dly = 4'h5;
    vq(n); pulse(n); svc(l2);
    chk(l2 - l1, 4);
    chk(l1 + 1, 7);
    chk(l2 + 1, 11);
    jc = 1'b1;
    en[40] = 1'b1; en[50] = 1'b1; prio[160+:4] = 4'h2; prio[200+:4] = 4'h9;
    vq(50); vq(40);
    src[40] = 1'b1; src[50] = 1'b1; src[60] = 1'b1; step(2); src = '0;
    svc(l1); svc(l1);
    chk(flg[60], 1);
    // mixed modes on all channels, interleaved to show they stay apart
    for (c = 0; c < 8; c = c + 1) begin
      r = lfsr(r);
      en[64+c] = 1'b1; peripheral_event_transfer_ctrl[64+c] = 1'b1; chn[3*(64+c)+:3] = c[2:0];
      csel = c[2:0]; csrc = r[23:0]; cdst = {r[7:0], r[31:16]}; ccnt = 8'h2;
      {cont, idst, isrc, byt} = {c[0], r[26:24]};
      m_md[c] = {c[0], r[26:24]}; m_s[c] = csrc; m_d[c] = cdst; m_cnt[c] = 8'h2;
      wr = 1'b1; step(1); wr = 1'b0; step(1);
    end
    for (i = 0; i < 3; i = i + 1) begin
      for (c = 0; c < 8; c = c + 1) begin
        req(c); pulse(64 + c); svc(l1);
      end
    end
    dly = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      r = lfsr(r);
      ssel[2*i+:2] = r[1:0]; en[88+i] = 1'b1;
      shs[4*i+((r[1:0]+1)%4)] = 1'b1; step(3);
      chk(flg[88+i], 0); step(3); shs = '0;
      vq(88 + i); shs[4*i+r[1:0]] = 1'b1; step(2); shs = '0; svc(l1);
    end
    // pass on miss: pattern 5 never matches a single high line
    miss = 4'hF;
    for (i = 0; i < 3; i = i + 1) begin
      en[92+i] = 1'b1; edg[2*i+:2] = i + 1; rte[2*i+:2] = i;
      if (i != 1) vq(92 + i);
      ext[i] = 1'b1;
      if (i != 1) svc(l1); else step(6);
      if (i != 0) vq(92 + i);
      ext[i] = 1'b0;
      if (i != 0) svc(l1); else step(6);
      chk(flg[92+i], 0);
    end
    miss = 4'h0; pat = 4'h1;
    vq(92); ext[0] = 1'b1; svc(l1); ext[0] = 1'b0; step(4);
    pat = 4'h5; ext[0] = 1'b1; step(3); chk(flg[92], 0);
    step(5); chk({irq, xreq}, 0); ext[0] = 1'b0; step(2);
    expq.push_back({2'b0, 7'h7F, 48'h0});
    trap = 1'b1; step(1); trap = 1'b0; svc(l1);
    chk(expq.size(), 0);
    conclude;
  end
endmodule // iaet_top_test
